// file: pkg/dgc_pkg.sv
// Shared constants and carrier types for the DAC gain and offset correction block.
`default_nettype none

package dgc_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// Widths.
	localparam int CODE_W = 18;
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam int STRB_W = DATA_W / 8;

	////////////////////////////////////////////////////////////////////////////////
	// Register byte addresses.
	localparam logic [ADDR_W-1:0] ADDR_CODE = 8'h00;
	localparam logic [ADDR_W-1:0] ADDR_GAIN = 8'h04;
	localparam logic [ADDR_W-1:0] ADDR_OFFS = 8'h08;
	localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h0C;
	localparam logic [ADDR_W-1:0] ADDR_MODE = 8'h10;
	localparam logic [ADDR_W-1:0] ADDR_CORR = 8'h14;

	////////////////////////////////////////////////////////////////////////////////
	// Values after reset and code limits.
	localparam logic [CODE_W-1:0] CODE_RST = 18'h0_0000;
	localparam logic [CODE_W-1:0] GAIN_RST = 18'h3_FFFF;
	localparam logic [CODE_W-1:0] OFFS_RST = 18'h0_0000;
	localparam logic [CODE_W-1:0] CODE_MAX = 18'h1_FFFF;
	localparam logic [CODE_W-1:0] CODE_MIN = 18'h2_0000;

	////////////////////////////////////////////////////////////////////////////////
	// Output mode field and status bit positions.
	localparam logic [1:0] MODE_HIZ    = 2'h0;
	localparam logic [1:0] MODE_VOLT   = 2'h1;
	localparam logic [1:0] MODE_VOLT25 = 2'h2;
	localparam logic [1:0] MODE_CURR   = 2'h3;
	localparam logic [1:0] MODE_RST    = MODE_HIZ;
	localparam int         STAT_BUSY   = 0;
	localparam int         STAT_CLIP   = 1;

	////////////////////////////////////////////////////////////////////////////////
	// Bus responses.
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	////////////////////////////////////////////////////////////////////////////////
	// Timing: the correction must finish inside the host's wait time.
	localparam int CLK_HZ       = 10_000_000;
	localparam int CALC_TIME_NS = 2500;
	localparam int CALC_MAX_CYC = CALC_TIME_NS * (CLK_HZ / 1_000_000) / 1000;
	localparam int CALC_LAT     = CODE_W + 4;

	////////////////////////////////////////////////////////////////////////////////
	// Types.
	typedef enum logic [1:0] {CALC_IDLE, CALC_MUL, CALC_ADD} dgc_calc_e;

	typedef struct packed {
		logic              req;
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] data;
		logic [STRB_W-1:0] strb;
	} dgc_wr_s;

	typedef struct packed {
		logic              req;
		logic [ADDR_W-1:0] addr;
	} dgc_rd_s;

	typedef struct packed {
		logic [DATA_W-1:0] data;
		logic              err;
	} dgc_rdata_s;

	typedef struct packed {
		logic [CODE_W-1:0] code;
		logic [CODE_W-1:0] gain;
		logic [CODE_W-1:0] offs;
	} dgc_coef_s;

endpackage

`default_nettype wire

// file: hdl/dgc_axil.sv
// AXI4-Lite slave front end: one write and one read in flight, registered answers.
`default_nettype none

module dgc_axil (
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	input  wire logic [dgc_pkg::ADDR_W-1:0]    awaddr,
	input  wire logic                          awvalid,
	output logic                               awready,
	input  wire logic [dgc_pkg::DATA_W-1:0]    wdata,
	input  wire logic [dgc_pkg::STRB_W-1:0]    wstrb,
	input  wire logic                          wvalid,
	output logic                               wready,
	output logic [1:0]                         bresp,
	output logic                               bvalid,
	input  wire logic                          bready,
	input  wire logic [dgc_pkg::ADDR_W-1:0]    araddr,
	input  wire logic                          arvalid,
	output logic                               arready,
	output logic [dgc_pkg::DATA_W-1:0]         rdata,
	output logic [1:0]                         rresp,
	output logic                               rvalid,
	input  wire logic                          rready,
	output dgc_pkg::dgc_wr_s                   wr,
	input  wire logic                          wr_err,
	output dgc_pkg::dgc_rd_s                   rd,
	input  wire dgc_pkg::dgc_rdata_s           rd_ans
);

	typedef struct packed {
		logic                       awready;
		logic                       wready;
		logic [dgc_pkg::ADDR_W-1:0] awaddr;
		logic [dgc_pkg::DATA_W-1:0] wdata;
		logic [dgc_pkg::STRB_W-1:0] wstrb;
		logic                       bvalid;
		logic [1:0]                 bresp;
		logic                       arready;
		logic [dgc_pkg::ADDR_W-1:0] araddr;
		logic                       rvalid;
		logic [dgc_pkg::DATA_W-1:0] rdata;
		logic [1:0]                 rresp;
	} dgc_axil_s;

	localparam dgc_axil_s RST = '{awready: 1'b1, wready: 1'b1, arready: 1'b1, bresp: dgc_pkg::RESP_OKAY,
		rresp: dgc_pkg::RESP_OKAY, default: '0};

	dgc_axil_s q;
	dgc_axil_s n;

	////////////////////////////////////////////////////////////////////////////////
	// A write is issued once address and data are both held and the last answer is gone.
	assign wr.req  = !q.awready && !q.wready && !q.bvalid;
	assign wr.addr = q.awaddr;
	assign wr.data = q.wdata;
	assign wr.strb = q.wstrb;
	assign rd.req  = !q.arready && !q.rvalid;
	assign rd.addr = q.araddr;

	always_comb begin
		n = q;
		if (awvalid && q.awready) begin
			n.awready = 1'b0;
			n.awaddr  = awaddr;
		end
		if (wvalid && q.wready) begin
			n.wready = 1'b0;
			n.wdata  = wdata;
			n.wstrb  = wstrb;
		end
		if (wr.req) begin
			n.bvalid = 1'b1;
			n.bresp  = wr_err ? dgc_pkg::RESP_SLVERR : dgc_pkg::RESP_OKAY;
		end
		if (q.bvalid && bready) begin
			n.bvalid  = 1'b0;
			n.awready = 1'b1;
			n.wready  = 1'b1;
		end
		if (arvalid && q.arready) begin
			n.arready = 1'b0;
			n.araddr  = araddr;
		end
		if (rd.req) begin
			n.rvalid = 1'b1;
			n.rdata  = rd_ans.data;
			n.rresp  = rd_ans.err ? dgc_pkg::RESP_SLVERR : dgc_pkg::RESP_OKAY;
		end
		if (q.rvalid && rready) begin
			n.rvalid  = 1'b0;
			n.arready = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= RST;
		end else begin
			q <= n;
		end
	end

	assign awready = q.awready;
	assign wready  = q.wready;
	assign bvalid  = q.bvalid;
	assign bresp   = q.bresp;
	assign arready = q.arready;
	assign rvalid  = q.rvalid;
	assign rdata   = q.rdata;
	assign rresp   = q.rresp;

endmodule // dgc_axil

`default_nettype wire

// file: hdl/dgc_calc.sv
// Sequential gain and offset correction: shift-add multiply, floor scaling, saturation.
`default_nettype none

module dgc_calc (
	input  wire logic                        aclk,
	input  wire logic                        aresetn,
	input  wire logic                        start,
	input  wire dgc_pkg::dgc_coef_s          coef,
	output logic                             done,
	output logic [dgc_pkg::CODE_W-1:0]       result,
	output logic                             clipped
);

	localparam int W  = dgc_pkg::CODE_W;
	localparam int AW = 2 * W + 2;

	typedef struct packed {
		dgc_pkg::dgc_calc_e st;
		logic [4:0]         cnt;
		logic [AW-1:0]      acc;
		logic [AW-1:0]      mc;
		logic [W:0]         mult;
		logic [W-1:0]       offs;
		logic [W-1:0]       result;
		logic               clipped;
		logic               done;
	} dgc_calc_s;

	localparam dgc_calc_s RST = '{st: dgc_pkg::CALC_IDLE, default: '0};

	dgc_calc_s          q;
	dgc_calc_s          n;
	logic signed [W+1:0] sum;

	always_comb begin
		n      = q;
		n.done = 1'b0;
		// Keeping the high bits of the product is an arithmetic shift, so it floors.
		sum = $signed(q.acc[AW-1:W]) + $signed({{2{q.offs[W-1]}}, q.offs});
		case (q.st)
			dgc_pkg::CALC_IDLE: begin
			end
			dgc_pkg::CALC_MUL: begin
				if (q.mult[0]) begin
					n.acc = q.acc + q.mc;
				end
				n.mc   = {q.mc[AW-2:0], 1'b0};
				n.mult = {1'b0, q.mult[W:1]};
				n.cnt  = q.cnt - 5'h1;
				if (q.cnt == 5'h0) begin
					n.st = dgc_pkg::CALC_ADD;
				end
			end
			dgc_pkg::CALC_ADD: begin
				n.st      = dgc_pkg::CALC_IDLE;
				n.done    = 1'b1;
				n.clipped = 1'b0;
				n.result  = sum[W-1:0];
				if (sum > $signed({2'b00, dgc_pkg::CODE_MAX})) begin
					n.result  = dgc_pkg::CODE_MAX;
					n.clipped = 1'b1;
				end else if (sum < $signed({2'b11, dgc_pkg::CODE_MIN})) begin
					n.result  = dgc_pkg::CODE_MIN;
					n.clipped = 1'b1;
				end
			end
			default: begin
				n.st = dgc_pkg::CALC_IDLE;
			end
		endcase
		// A new start always restarts with the latest coefficients and suppresses a stale result.
		if (start) begin
			n.st   = dgc_pkg::CALC_MUL;
			n.done = 1'b0;
			n.cnt  = 5'(W);
			n.acc  = '0;
			n.mc   = {{(AW - W){coef.code[W-1]}}, coef.code};
			n.mult = {1'b0, coef.gain} + 19'h0_0001;
			n.offs = coef.offs;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= RST;
		end else begin
			q <= n;
		end
	end

	assign done    = q.done;
	assign result  = q.result;
	assign clipped = q.clipped;

endmodule // dgc_calc

`default_nettype wire

// file: hdl/dgc_top.sv
// Top of the DAC gain and offset correction block with its AXI4-Lite register file.
//
// What this block does
// - After reset the output is high impedance; switching into voltage or current mode drives a zero code.
// - Every output code except the zero loaded on a mode switch is corrected with an 18-bit gain and an 18-bit offset before it reaches the converter.
// - The 18-bit data code is signed two's complement, zero giving zero output and all-ones minus one step.
// - The gain is unsigned, all zeros meaning one part in two to the eighteenth and all ones meaning unity.
// - The offset is a signed 18-bit code spanning about minus to plus half scale.
// - A corrected result outside the code range clips to the nearest extreme instead of wrapping.
// - The positive 25 V voltage setting uses the same correction and saturation, the shift coming afterwards.
// - Writing the data, gain or offset register starts a new correction, and the output updates when it ends.
// - The corrected code is data times gain plus one over two to the eighteenth, plus offset, saturated.
// - A busy bit is high during the correction, which the host may poll or wait out for 2.5 us.
//
// Local design decisions: register access over AXI4-Lite and the address map.
`default_nettype none

module dgc_top (
	input  wire logic                          aclk,
	input  wire logic                          aresetn,
	input  wire logic [dgc_pkg::ADDR_W-1:0]    s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output logic                               s_axi_awready,
	input  wire logic [dgc_pkg::DATA_W-1:0]    s_axi_wdata,
	input  wire logic [dgc_pkg::STRB_W-1:0]    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output logic                               s_axi_wready,
	output logic [1:0]                         s_axi_bresp,
	output logic                               s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	input  wire logic [dgc_pkg::ADDR_W-1:0]    s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output logic                               s_axi_arready,
	output logic [dgc_pkg::DATA_W-1:0]         s_axi_rdata,
	output logic [1:0]                         s_axi_rresp,
	output logic                               s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	output logic [dgc_pkg::CODE_W-1:0]         dac_code,
	output logic                               dac_load,
	output logic                               out_drive_en,
	output logic                               out_current_mode,
	output logic                               out_shift_25v,
	output logic                               calc_busy
);

	localparam int W = dgc_pkg::CODE_W;

	////////////////////////////////////////////////////////////////////////////////
	// The host may rely on the fixed wait, so the datapath must never be slower.
	generate
		if (dgc_pkg::CALC_LAT > dgc_pkg::CALC_MAX_CYC) begin : g_lat_check
			$error("Correction latency exceeds the host wait time.");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// State.
	typedef struct packed {
		dgc_pkg::dgc_coef_s coef;
		logic [1:0]         mode;
		logic               start;
		logic               busy;
		logic               clip;
		logic [W-1:0]       corr;
		logic [W-1:0]       dac_code;
		logic               dac_load;
		logic               drive_en;
		logic               cur_mode;
		logic               shift25;
	} dgc_top_s;

	localparam dgc_top_s RST = '{
		coef:     '{code: dgc_pkg::CODE_RST, gain: dgc_pkg::GAIN_RST, offs: dgc_pkg::OFFS_RST},
		mode:     dgc_pkg::MODE_RST,
		corr:     dgc_pkg::CODE_RST,
		dac_code: dgc_pkg::CODE_RST,
		default:  '0
	};

	dgc_top_s             q;
	dgc_top_s             n;
	dgc_pkg::dgc_wr_s     wr;
	dgc_pkg::dgc_rd_s     rd;
	dgc_pkg::dgc_rdata_s  rd_ans;
	dgc_pkg::dgc_rdata_s  cur;
	logic [dgc_pkg::DATA_W-1:0] wv;
	logic                 cdone;
	logic [W-1:0]         cres;
	logic                 cclip;

	////////////////////////////////////////////////////////////////////////////////
	// Register read view; unmapped addresses answer with an error.
	function automatic dgc_pkg::dgc_rdata_s reg_read(input dgc_top_s s, input logic [dgc_pkg::ADDR_W-1:0] a);
		dgc_pkg::dgc_rdata_s r;
		r.data = 32'h0000_0000;
		r.err  = 1'b0;
		case ({a[dgc_pkg::ADDR_W-1:2], 2'b00})
			dgc_pkg::ADDR_CODE: begin
				r.data[W-1:0] = s.coef.code;
			end
			dgc_pkg::ADDR_GAIN: begin
				r.data[W-1:0] = s.coef.gain;
			end
			dgc_pkg::ADDR_OFFS: begin
				r.data[W-1:0] = s.coef.offs;
			end
			dgc_pkg::ADDR_STAT: begin
				r.data[dgc_pkg::STAT_BUSY] = s.busy;
				r.data[dgc_pkg::STAT_CLIP] = s.clip;
			end
			dgc_pkg::ADDR_MODE: begin
				r.data[1:0] = s.mode;
			end
			dgc_pkg::ADDR_CORR: begin
				r.data[W-1:0] = s.corr;
			end
			default: begin
				r.err = 1'b1;
			end
		endcase
		return r;
	endfunction

	// Byte lanes without a strobe keep their old contents.
	function automatic logic [dgc_pkg::DATA_W-1:0] lane_merge(
		input logic [dgc_pkg::DATA_W-1:0] old,
		input logic [dgc_pkg::DATA_W-1:0] data,
		input logic [dgc_pkg::STRB_W-1:0] strb
	);
		logic [dgc_pkg::DATA_W-1:0] m;
		m = old;
		for (int i = 0; i < dgc_pkg::STRB_W; i++) begin
			if (strb[i]) begin
				m[8*i +: 8] = data[8*i +: 8];
			end
		end
		return m;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Bus slave and correction datapath.
	dgc_axil u_axil (
		.aclk    (aclk),
		.aresetn (aresetn),
		.awaddr  (s_axi_awaddr),
		.awvalid (s_axi_awvalid),
		.awready (s_axi_awready),
		.wdata   (s_axi_wdata),
		.wstrb   (s_axi_wstrb),
		.wvalid  (s_axi_wvalid),
		.wready  (s_axi_wready),
		.bresp   (s_axi_bresp),
		.bvalid  (s_axi_bvalid),
		.bready  (s_axi_bready),
		.araddr  (s_axi_araddr),
		.arvalid (s_axi_arvalid),
		.arready (s_axi_arready),
		.rdata   (s_axi_rdata),
		.rresp   (s_axi_rresp),
		.rvalid  (s_axi_rvalid),
		.rready  (s_axi_rready),
		.wr      (wr),
		.wr_err  (cur.err),
		.rd      (rd),
		.rd_ans  (rd_ans)
	);

	dgc_calc u_calc (
		.aclk    (aclk),
		.aresetn (aresetn),
		.start   (q.start),
		.coef    (q.coef),
		.done    (cdone),
		.result  (cres),
		.clipped (cclip)
	);

	assign rd_ans = reg_read(q, rd.addr);

	////////////////////////////////////////////////////////////////////////////////
	// Register writes, recalculation start and output update.
	always_comb begin
		n          = q;
		n.start    = 1'b0;
		n.dac_load = 1'b0;
		cur        = reg_read(q, wr.addr);
		wv         = lane_merge(cur.data, wr.data, wr.strb);
		// A result that lands while a newer start is queued keeps busy high.
		if (cdone) begin
			n.dac_code = cres;
			n.dac_load = 1'b1;
			n.corr     = cres;
			n.clip     = cclip;
			n.busy     = q.start;
		end
		if (wr.req && !cur.err) begin
			case ({wr.addr[dgc_pkg::ADDR_W-1:2], 2'b00})
				dgc_pkg::ADDR_CODE: begin
					n.coef.code = wv[W-1:0];
					n.start     = 1'b1;
				end
				dgc_pkg::ADDR_GAIN: begin
					n.coef.gain = wv[W-1:0];
					n.start     = 1'b1;
				end
				dgc_pkg::ADDR_OFFS: begin
					n.coef.offs = wv[W-1:0];
					n.start     = 1'b1;
				end
				dgc_pkg::ADDR_MODE: begin
					n.mode = wv[1:0];
					if (wv[1:0] != q.mode) begin
						n.dac_code = dgc_pkg::CODE_RST;
						n.dac_load = 1'b1;
					end
				end
				default: begin
				end
			endcase
		end
		if (n.start) begin
			n.busy = 1'b1;
		end
		n.drive_en = n.mode != dgc_pkg::MODE_HIZ;
		n.cur_mode = n.mode == dgc_pkg::MODE_CURR;
		// The 25 V shift is analog only; the code path is the same as the bipolar setting.
		n.shift25  = n.mode == dgc_pkg::MODE_VOLT25;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= RST;
		end else begin
			q <= n;
		end
	end

	assign dac_code         = q.dac_code;
	assign dac_load         = q.dac_load;
	assign out_drive_en     = q.drive_en;
	assign out_current_mode = q.cur_mode;
	assign out_shift_25v    = q.shift25;
	assign calc_busy        = q.busy;

endmodule // dgc_top

`default_nettype wire

// file: bench/dgc_top_sva.sv
// Concurrent checks on the ports of the correction block top.
`default_nettype none

module dgc_top_sva (
	input wire logic                       aclk,
	input wire logic                       aresetn,
	input wire logic                       s_axi_awready,
	input wire logic                       s_axi_wready,
	input wire logic                       s_axi_bvalid,
	input wire logic                       s_axi_bready,
	input wire logic                       s_axi_arready,
	input wire logic                       s_axi_rvalid,
	input wire logic                       s_axi_rready,
	input wire logic [dgc_pkg::CODE_W-1:0] dac_code,
	input wire logic                       dac_load,
	input wire logic                       out_drive_en,
	input wire logic                       out_current_mode,
	input wire logic                       out_shift_25v,
	input wire logic                       calc_busy
);
	timeunit 1ns;
	timeprecision 1ns;

	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);

	////////////////////////////////////////////////////////////////////////////////
	busy_ends_load_a: assert property ($fell(calc_busy) |-> dac_load)
		else $error("busy fell without a load");
	// A new coefficient write legally restarts the correction, so each write answer restarts the wait.
	busy_bounded_a: assert property (calc_busy && $rose(s_axi_bvalid) |->
		##[1:25] (!calc_busy || $rose(s_axi_bvalid)))
		else $error("busy held too long");
	busy_cause_a: assert property ($rose(calc_busy) |-> $rose(s_axi_bvalid))
		else $error("busy rose without a write answer");
	code_hold_a: assert property (!dac_load |-> $stable(dac_code))
		else $error("output code changed without a load");
	drive_zero_a: assert property ($rose(out_drive_en) |-> dac_load && dac_code == '0)
		else $error("output enabled with a nonzero code");
	mode_excl_a: assert property (out_current_mode || out_shift_25v |-> out_drive_en
		&& !(out_current_mode && out_shift_25v))
		else $error("inconsistent output mode flags");
	load_pulse_a: assert property (dac_load |=> !dac_load)
		else $error("load longer than one cycle");
	wr_busy_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write channel ready while answer pending");
	b_done_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
		else $error("write answer not retired");
	r_done_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
		else $error("read answer not retired");

endmodule // dgc_top_sva

bind dgc_top dgc_top_sva i_sva (.aclk, .aresetn, .s_axi_awready, .s_axi_wready, .s_axi_bvalid,
	.s_axi_bready, .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .dac_code, .dac_load,
	.out_drive_en, .out_current_mode, .out_shift_25v, .calc_busy);

`default_nettype wire

// file: bench/dgc_host.sv
// Host-side AXI4-Lite master model that programs the correction registers.
`default_nettype none

module dgc_host (
	input  wire logic                       aclk,
	output var  logic [dgc_pkg::ADDR_W-1:0] s_axi_awaddr,
	output var  logic                       s_axi_awvalid,
	input  wire logic                       s_axi_awready,
	output var  logic [dgc_pkg::DATA_W-1:0] s_axi_wdata,
	output var  logic [dgc_pkg::STRB_W-1:0] s_axi_wstrb,
	output var  logic                       s_axi_wvalid,
	input  wire logic                       s_axi_wready,
	input  wire logic [1:0]                 s_axi_bresp,
	input  wire logic                       s_axi_bvalid,
	output var  logic                       s_axi_bready,
	output var  logic [dgc_pkg::ADDR_W-1:0] s_axi_araddr,
	output var  logic                       s_axi_arvalid,
	input  wire logic                       s_axi_arready,
	input  wire logic [dgc_pkg::DATA_W-1:0] s_axi_rdata,
	input  wire logic [1:0]                 s_axi_rresp,
	input  wire logic                       s_axi_rvalid,
	output var  logic                       s_axi_rready
);
	timeunit 1ns;
	timeprecision 1ns;

	// Ready to accept answers at all times; the answer waits are then only the slave's.
	initial begin
		s_axi_awaddr = 8'h00;
		s_axi_awvalid = 1'b0;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'hF;
		s_axi_wvalid = 1'b0;
		s_axi_bready = 1'b1;
		s_axi_araddr = 8'h00;
		s_axi_arvalid = 1'b0;
		s_axi_rready = 1'b1;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Ready and answers are sampled at the falling edge so the decision never races the slave.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r, input logic [3:0] s = 4'hF);
		logic ta, tw, tb;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		tb = 1'b0;
		while (!tb) begin
			@(negedge aclk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ta) begin
				s_axi_awvalid <= 1'b0;
				s_axi_awaddr <= ~a;
			end
			if (tw) begin
				s_axi_wvalid <= 1'b0;
				s_axi_wdata <= ~d;
			end
		end
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic ta, tr;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		tr = 1'b0;
		while (!tr) begin
			@(negedge aclk);
			ta = s_axi_arvalid && s_axi_arready;
			tr = s_axi_rvalid;
			d = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ta) begin
				s_axi_arvalid <= 1'b0;
				s_axi_araddr <= ~a;
			end
		end
	endtask

endmodule // dgc_host

`default_nettype wire

// file: bench/dac_gain_offset_correction_bench.sv
// Self-checking bench for the DAC gain and offset correction block.
`default_nettype none

module dac_gain_offset_correction_bench;
	timeunit 1ns;
	timeprecision 1ns;

	logic                       aclk, aresetn;
	logic [dgc_pkg::ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
	logic [dgc_pkg::DATA_W-1:0] s_axi_wdata, s_axi_rdata;
	logic [dgc_pkg::STRB_W-1:0] s_axi_wstrb;
	logic [1:0]                 s_axi_bresp, s_axi_rresp, r, m;
	logic                       s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic                       s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic                       s_axi_rvalid, s_axi_rready;
	logic [dgc_pkg::CODE_W-1:0] dac_code;
	logic                       dac_load, out_drive_en, out_current_mode, out_shift_25v, calc_busy;
	logic [31:0]                d;
	logic [18:0]                e;
	int                         failures, tests_run, n;
	logic [17:0] vc [6] = '{18'h0_0000, 18'h3_FFFF, 18'h2_0000, 18'h1_FFFF, 18'h2_0000, 18'h1_0000};
	logic [17:0] vg [6] = '{18'h3_FFFF, 18'h3_FFFF, 18'h0_0000, 18'h3_FFFF, 18'h3_FFFF, 18'h1_FFFF};
	logic [17:0] vo [6] = '{18'h0_0000, 18'h0_0000, 18'h0_0000, 18'h1_FFFF, 18'h2_0000, 18'h0_0005};
	logic [1:0]  vm [3] = '{dgc_pkg::MODE_VOLT, dgc_pkg::MODE_VOLT25, dgc_pkg::MODE_CURR};
	logic [7:0]  ra [4] = '{dgc_pkg::ADDR_CODE, dgc_pkg::ADDR_GAIN, dgc_pkg::ADDR_OFFS, dgc_pkg::ADDR_MODE};
	logic [31:0] rv [4] = '{32'h0000_0000, 32'h0003_FFFF, 32'h0000_0000, 32'h0000_0000};

	dgc_top i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
		.s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .dac_code, .dac_load, .out_drive_en, .out_current_mode, .out_shift_25v, .calc_busy);

	dgc_host i_host (.aclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
		.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

	////////////////////////////////////////////////////////////////////////////////
	// Reference: floored scaling, then offset, then saturation; bit 18 flags a clip.
	function automatic logic [18:0] corr(logic [17:0] c, logic [17:0] g, logic [17:0] o);
		longint p;
		p = ($signed(c) * (longint'(g) + 1)) >>> 18;
		p = p + longint'($signed(o));
		if (p > 131071) return {1'b1, 18'h1_FFFF};
		if (p < -131072) return {1'b1, 18'h2_0000};
		return {1'b0, p[17:0]};
	endfunction

	task automatic chk(string nm, logic [31:0] x, logic [31:0] y);
		tests_run++;
		if (y !== x) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", nm, x, y);
		end
	endtask

	// Polls status until the busy bit clears, bounded so a stuck bit cannot hang the run.
	task automatic settle;
		n = 0;
		do begin
			i_host.rd(dgc_pkg::ADDR_STAT, d, r);
			n++;
		end while (d[dgc_pkg::STAT_BUSY] !== 1'b0 && n < 40);
		chk("busy_clear", 32'h0, {31'h0, d[dgc_pkg::STAT_BUSY]});
	endtask

	task automatic finish_test;
		$display("checks %0d failures %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	initial begin
		#500_000;
		failures++;
		finish_test();
	end

	initial begin
		failures = 0;
		tests_run = 0;
		aresetn = 1'b0;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(posedge aclk);
		chk("drive_rst", 32'h0, out_drive_en);
		for (int i = 0; i < 4; i++) begin
			i_host.rd(ra[i], d, r);
			chk("reg_rst", rv[i], d);
		end
		i_host.rd(8'h18, d, r);
		chk("rd_unmapped", dgc_pkg::RESP_SLVERR, r);
		i_host.wr(8'h18, 32'h0000_0001, r);
		chk("wr_unmapped", dgc_pkg::RESP_SLVERR, r);
		i_host.wr(dgc_pkg::ADDR_STAT, 32'h0000_0003, r);
		chk("wr_status", dgc_pkg::RESP_OKAY, r);
		for (int i = 0; i < 6; i++) begin
			m = vm[i % 3];
			i_host.wr(dgc_pkg::ADDR_MODE, {30'h0, m}, r);
			chk("mode_zero", 32'h0, dac_code);
			chk("drive", 32'h1, out_drive_en);
			chk("current", m == dgc_pkg::MODE_CURR, out_current_mode);
			chk("shift", m == dgc_pkg::MODE_VOLT25, out_shift_25v);
			i_host.wr(dgc_pkg::ADDR_GAIN, {14'h0, vg[i]}, r);
			i_host.wr(dgc_pkg::ADDR_OFFS, {14'h0, vo[i]}, r);
			i_host.wr(dgc_pkg::ADDR_CODE, {14'h0, vc[i]}, r);
			i_host.rd(dgc_pkg::ADDR_STAT, d, r);
			chk("busy_set", 32'h1, {31'h0, d[dgc_pkg::STAT_BUSY]});
			settle();
			e = corr(vc[i], vg[i], vo[i]);
			chk("dac_code", {14'h0, e[17:0]}, dac_code);
			i_host.rd(dgc_pkg::ADDR_CORR, d, r);
			chk("readback", {14'h0, e[17:0]}, d);
			i_host.rd(dgc_pkg::ADDR_STAT, d, r);
			chk("clip", {31'h0, e[18]}, {31'h0, d[dgc_pkg::STAT_CLIP]});
		end
		// Only the lowest byte lane is strobed, so the upper gain bits must keep their last value.
		i_host.wr(dgc_pkg::ADDR_GAIN, 32'hFFFF_FFAB, r, 4'h1);
		i_host.rd(dgc_pkg::ADDR_GAIN, d, r);
		chk("gain_strobe", 32'h0001_FFAB, d);
		i_host.wr(dgc_pkg::ADDR_MODE, {30'h0, dgc_pkg::MODE_HIZ}, r);
		chk("hiz", 32'h0, out_drive_en);
		finish_test();
	end

endmodule // dac_gain_offset_correction_bench

`default_nettype wire
